//--- rtl/level_cross_detect.sv
// Purpose: falling and rising crossing detector for a 7-bit level
// Assumes: samples and level on the controller clock
// Notes: pulses last one cycle, on the sample that first lies past the level
`timescale 1ns/1ns
module level_cross_detect #(
  parameter int W = 7
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic sample_valid_in,
  input wire logic [W-1:0] sample_in,
  input wire logic [W-1:0] level_in,
  output logic rise_out,
  output logic fall_out
);
  logic above_q;
  logic primed_q;
  wire above_now = sample_in > level_in;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      above_q <= 1'b0;
      primed_q <= 1'b0;
    end else if (sample_valid_in) begin
      above_q <= above_now;
      primed_q <= 1'b1;
    end
  end

  // first sample only primes, so reset never looks like a crossing
  assign rise_out = sample_valid_in && primed_q && above_now && !above_q;
  assign fall_out = sample_valid_in && primed_q && !above_now && above_q;
endmodule : level_cross_detect

//--- rtl/line_mon_pkg.sv
// Purpose: constants, types and register map of the ac line monitor and startup gate
// Assumes: 250 MHz controller clock; line period kept in 10 us ticks
// Notes: 8-bit registers sit in the low bits of the 16-bit register data
package line_mon_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TICK_NS = 10000;
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam int INIT_WINDOW_MS = 40;
  localparam int INIT_WINDOW_TICKS = INIT_WINDOW_MS * 1000000 / TICK_NS;
  localparam int SAG_SHORT_MS = 2;
  localparam int SAG_LONG_MS = 4;
  localparam logic [15:0] SAG_SHORT_TICKS = 16'(SAG_SHORT_MS * 1000000 / TICK_NS);
  localparam logic [15:0] SAG_LONG_TICKS = 16'(SAG_LONG_MS * 1000000 / TICK_NS);
  // period limit registers count in 100 us steps
  localparam logic [7:0] LIMIT_TICKS_PER_LSB = 8'h0A;

  localparam logic [15:0] ADDR_ON_OFF_CMD = 16'h0001;
  localparam logic [15:0] ADDR_ON_OFF_SOURCE = 16'h0002;
  localparam logic [15:0] ADDR_START_THR = 16'h0035;
  localparam logic [15:0] ADDR_WARN_THR = 16'h0036;
  localparam logic [15:0] ADDR_UV_LIMIT = 16'h0059;
  localparam logic [15:0] ADDR_INPUT_STATUS = 16'h007C;
  localparam logic [15:0] ADDR_CROSS_LEVEL = 16'hFE25;
  localparam logic [15:0] ADDR_LINE_AVG = 16'hFE26;
  localparam logic [15:0] ADDR_MIN_PERIOD = 16'hFE27;
  localparam logic [15:0] ADDR_MAX_PERIOD = 16'hFE28;
  localparam logic [15:0] ADDR_SAG_CFG = 16'hFE2E;
  localparam logic [15:0] ADDR_LINE_PERIOD = 16'hFE85;

  localparam int CMD_ON_BIT = 7;
  localparam int SRC_PIN_POL_BIT = 1;
  localparam int SRC_CMD_EN_BIT = 2;
  localparam int SRC_PIN_EN_BIT = 3;
  localparam int SAG_MODE_LSB = 3;
  localparam int STAT_BROWNOUT_BIT = 3;
  localparam int STAT_UV_BIT = 4;
  localparam int STAT_SAG_BIT = 5;

  localparam logic [7:0] SOURCE_RST = 8'h0A;
  localparam logic [7:0] CROSS_LEVEL_RST = 8'h20;
  localparam logic [7:0] MIN_PERIOD_RST = 8'h50;
  localparam logic [7:0] MAX_PERIOD_RST = 8'hC8;
  localparam logic [7:0] STATUS_RST = 8'h08;

  typedef enum logic [1:0] {
    SAG_QUARTER = 2'b00,
    SAG_HALF = 2'b01,
    SAG_ABS_SHORT = 2'b10,
    SAG_ABS_LONG = 2'b11
  } sag_mode_t;

  typedef enum logic [1:0] {
    ST_WAIT_ON = 2'b00,
    ST_DETECT = 2'b01,
    ST_RUN = 2'b10
  } start_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] period;
    logic period_valid;
    logic [15:0] zero_cross_stamp;
    logic zero_cross_valid;
  } line_info_t;
endpackage : line_mon_pkg

//--- rtl/line_monitor.sv
// Purpose: ac line period, zero crossing, average, startup gate and sag warning
// Assumes: line samples and rms come from logic on this clock; the on/off pin is asynchronous
// Notes: register port answers one cycle after a read or write strobe
`timescale 1ns/1ns
module line_monitor
  import line_mon_pkg::*;
#(
  parameter int SENSE_W = 16
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic supply_on_request_in,
  input wire logic sense_valid_in,
  input wire logic [SENSE_W-1:0] rectified_line_sense_in,
  input wire logic [15:0] rms_line_in,
  input wire reg_req_t reg_req_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_ack_out,
  output logic reg_err_out,
  output line_info_t ctrl_line_info_out,
  output line_info_t meter_line_info_out,
  output logic soft_start_go_out,
  output logic converter_on_out,
  output logic line_good_n_out,
  output logic uv_shutdown_out
);
  // the crossing slice needs 7 bits and the sag compare takes 16 at most
  if (SENSE_W < 8 || SENSE_W > 16) begin : g_bad_sense_w
    $error("SENSE_W must be 8 to 16");
  end

  // registers
  logic [7:0] cmd_q;
  logic [7:0] source_q;
  logic [15:0] start_thr_q;
  logic [15:0] warn_thr_q;
  logic [15:0] uv_limit_q;
  logic [7:0] status_q;
  logic [7:0] cross_level_q;
  logic [7:0] min_period_q;
  logic [7:0] max_period_q;
  logic [7:0] sag_cfg_q;
  logic [15:0] period_q;
  logic [6:0] avg_q;

  // pin synchroniser: only the second stage is read
  logic pin_meta_q;
  logic pin_sync_q;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= supply_on_request_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // on request from the selected source
  wire pin_on = pin_sync_q ~^ source_q[SRC_PIN_POL_BIT];
  wire pin_ok = !source_q[SRC_PIN_EN_BIT] || pin_on;
  wire cmd_ok = !source_q[SRC_CMD_EN_BIT] || cmd_q[CMD_ON_BIT];
  wire any_src = source_q[SRC_PIN_EN_BIT] || source_q[SRC_CMD_EN_BIT];
  wire on_req = any_src && pin_ok && cmd_ok;

  // tick prescaler and time stamp
  logic [11:0] pre_q;
  logic [15:0] stamp_q;
  wire tick = pre_q == 12'(TICK_CYC - 1);
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pre_q <= 12'h000;
      stamp_q <= 16'h0000;
    end else begin
      pre_q <= tick ? 12'h000 : pre_q + 12'h001;
      stamp_q <= stamp_q + {15'h0000, tick};
    end
  end

  start_state_t state_q;
  start_state_t state_d;
  wire measuring = state_q != ST_WAIT_ON;

  // 40 ms initial window, counted from the on request
  logic [15:0] init_ticks_q;
  wire init_done = init_ticks_q >= 16'(INIT_WINDOW_TICKS);
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !measuring) init_ticks_q <= 16'h0000;
    else if (tick && !init_done) init_ticks_q <= init_ticks_q + 16'h0001;
  end

  // crossing detection against the set level, then the average
  wire [6:0] sample7 = rectified_line_sense_in[SENSE_W-1 -: 7];
  wire [6:0] level = init_done ? avg_q : cross_level_q[6:0];
  logic rise_ev;
  logic fall_raw;
  level_cross_detect #(.W(7)) u_cross (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in || !measuring),
    .sample_valid_in(sense_valid_in),
    .sample_in(sample7),
    .level_in(level),
    .rise_out(rise_ev),
    .fall_out(fall_raw)
  );

  // running average with 1/16 weight per sample (about 16 samples), latched at each falling crossing
  logic [10:0] avg_acc_q;
  wire [10:0] avg_acc_d = avg_acc_q - {4'h0, avg_acc_q[10:4]} + {4'h0, sample7};
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      avg_acc_q <= 11'h000;
      avg_q <= 7'h00;
    end else begin
      if (sense_valid_in) avg_acc_q <= avg_acc_d;
      if (fall_raw) avg_q <= avg_acc_q[10:4];
    end
  end

  // period measurement
  logic have_fall_q;
  logic [15:0] last_fall_q;
  logic [15:0] last_rise_q;
  wire [15:0] since_fall = stamp_q - last_fall_q;
  // widen before the product: 0xC8 steps is 2000 ticks, past 8 bits
  wire [15:0] max_ticks = 16'(max_period_q) * 16'(LIMIT_TICKS_PER_LSB);
  wire [15:0] min_ticks = 16'(min_period_q) * 16'(LIMIT_TICKS_PER_LSB);
  // rectified falls come once per half period; the line period is twice that
  wire [16:0] raw_period = {since_fall, 1'b0};
  wire out_of_range = raw_period > {1'b0, max_ticks} || raw_period < {1'b0, min_ticks};
  wire [15:0] clamped = out_of_range ? max_ticks : raw_period[15:0];
  // nothing crossed for a whole longest period: report the longest one
  wire no_cross = measuring && have_fall_q && tick && since_fall >= max_ticks;
  wire half_ev = fall_raw && have_fall_q;
  wire [15:0] rise_span = stamp_q - last_rise_q;
  wire [15:0] mid_stamp = last_rise_q + {1'b0, rise_span[15:1]};

  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !measuring) begin
      have_fall_q <= 1'b0;
      last_fall_q <= 16'h0000;
      last_rise_q <= 16'h0000;
    end else begin
      if (rise_ev) last_rise_q <= stamp_q;
      if (fall_raw || no_cross) last_fall_q <= stamp_q;
      if (fall_raw) have_fall_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      period_q <= 16'h0000;
    end else if (half_ev) begin
      period_q <= clamped;
    end else if (no_cross || (measuring && !have_fall_q && period_q == 16'h0000)) begin
      period_q <= max_ticks;
    end
  end

  // same record to the control loop and the metering block
  line_info_t info_q;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      info_q <= '0;
    end else begin
      info_q.period_valid <= half_ev || no_cross;
      if (half_ev || no_cross) info_q.period <= half_ev ? clamped : max_ticks;
      info_q.zero_cross_valid <= fall_raw;
      if (fall_raw) info_q.zero_cross_stamp <= mid_stamp;
    end
  end
  assign ctrl_line_info_out = info_q;
  assign meter_line_info_out = info_q;

  // startup gate
  wire start_ok = half_ev && rms_line_in > start_thr_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT_ON: begin
        if (on_req) state_d = ST_DETECT;
      end
      ST_DETECT: begin
        if (!on_req) state_d = ST_WAIT_ON;
        else if (start_ok) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (!on_req) state_d = ST_WAIT_ON;
      end
      default: state_d = ST_WAIT_ON;
    endcase
  end

  logic go_q;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_q <= ST_WAIT_ON;
      go_q <= 1'b0;
    end else begin
      state_q <= state_d;
      go_q <= state_q == ST_DETECT && state_d == ST_RUN;
    end
  end
  assign soft_start_go_out = go_q;
  assign converter_on_out = state_q == ST_RUN;

  // sag watch: counts ticks below the warning level
  logic [15:0] below_ticks_q;
  logic sag_live_q;
  wire [15:0] inst16 = 16'(rectified_line_sense_in);
  wire below = inst16 < warn_thr_q;
  logic [15:0] sag_limit;
  always_comb begin
    case (sag_mode_t'(sag_cfg_q[SAG_MODE_LSB +: 2]))
      SAG_QUARTER: sag_limit = {2'b00, period_q[15:2]};
      SAG_HALF: sag_limit = {1'b0, period_q[15:1]};
      SAG_ABS_SHORT: sag_limit = SAG_SHORT_TICKS;
      default: sag_limit = SAG_LONG_TICKS;
    endcase
  end
  wire sag_trip = state_q == ST_RUN && below && below_ticks_q > sag_limit;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in || state_q != ST_RUN || !below) begin
      below_ticks_q <= 16'h0000;
    end else if (tick && below_ticks_q != 16'hFFFF) begin
      below_ticks_q <= below_ticks_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) sag_live_q <= 1'b0;
    else if (sag_trip) sag_live_q <= 1'b1;
    else if (!below || state_q != ST_RUN) sag_live_q <= 1'b0;
  end
  // warning only: sag reaches the line-good pin and no control path
  assign line_good_n_out = sag_live_q;

  // shutdown decision uses the uv limit alone, never the warning level
  logic uv_q;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) uv_q <= 1'b0;
    else uv_q <= state_q == ST_RUN && rms_line_in < uv_limit_q;
  end
  assign uv_shutdown_out = uv_q;

  // register port
  wire wr = reg_req_in.wr;
  wire [15:0] wd = reg_req_in.wdata;
  wire [15:0] ad = reg_req_in.addr;
  wire stat_w = wr && ad == ADDR_INPUT_STATUS;
  wire [7:0] stat_clr = stat_w ? wd[7:0] : 8'h00;
  logic [7:0] stat_set;
  always_comb begin
    stat_set = 8'h00;
    stat_set[STAT_SAG_BIT] = sag_trip;
    stat_set[STAT_BROWNOUT_BIT] = sag_trip;
    stat_set[STAT_UV_BIT] = uv_q;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cmd_q <= 8'h00;
      source_q <= SOURCE_RST;
      start_thr_q <= 16'h0000;
      warn_thr_q <= 16'h0000;
      uv_limit_q <= 16'h0000;
      cross_level_q <= CROSS_LEVEL_RST;
      min_period_q <= MIN_PERIOD_RST;
      max_period_q <= MAX_PERIOD_RST;
      sag_cfg_q <= 8'h00;
    end else if (wr) begin
      if (ad == ADDR_ON_OFF_CMD) cmd_q <= wd[7:0];
      else if (ad == ADDR_ON_OFF_SOURCE) source_q <= wd[7:0];
      else if (ad == ADDR_START_THR) start_thr_q <= wd;
      else if (ad == ADDR_WARN_THR) warn_thr_q <= wd;
      else if (ad == ADDR_UV_LIMIT) uv_limit_q <= wd;
      else if (ad == ADDR_CROSS_LEVEL) cross_level_q <= {1'b0, wd[6:0]};
      else if (ad == ADDR_MIN_PERIOD) min_period_q <= wd[7:0];
      else if (ad == ADDR_MAX_PERIOD) max_period_q <= wd[7:0];
      else if (ad == ADDR_SAG_CFG) sag_cfg_q <= wd[7:0];
    end
  end

  // status: write one to clear, a new event in the same cycle wins
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      status_q <= STATUS_RST;
    end else if (start_ok && state_q == ST_DETECT) begin
      status_q <= (status_q & ~stat_clr & ~(8'h01 << STAT_BROWNOUT_BIT)) | stat_set;
    end else begin
      status_q <= (status_q & ~stat_clr) | stat_set;
    end
  end

  logic [15:0] rdata;
  logic hit;
  always_comb begin
    hit = 1'b1;
    rdata = 16'h0000;
    if (ad == ADDR_ON_OFF_CMD) rdata = {8'h00, cmd_q};
    else if (ad == ADDR_ON_OFF_SOURCE) rdata = {8'h00, source_q};
    else if (ad == ADDR_START_THR) rdata = start_thr_q;
    else if (ad == ADDR_WARN_THR) rdata = warn_thr_q;
    else if (ad == ADDR_UV_LIMIT) rdata = uv_limit_q;
    else if (ad == ADDR_INPUT_STATUS) rdata = {8'h00, status_q};
    else if (ad == ADDR_CROSS_LEVEL) rdata = {8'h00, cross_level_q};
    else if (ad == ADDR_LINE_AVG) rdata = {9'h000, avg_q};
    else if (ad == ADDR_MIN_PERIOD) rdata = {8'h00, min_period_q};
    else if (ad == ADDR_MAX_PERIOD) rdata = {8'h00, max_period_q};
    else if (ad == ADDR_SAG_CFG) rdata = {8'h00, sag_cfg_q};
    else if (ad == ADDR_LINE_PERIOD) rdata = period_q;
    else hit = 1'b0;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      reg_rdata_out <= 16'h0000;
      reg_ack_out <= 1'b0;
      reg_err_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_req_in.rd && hit ? rdata : 16'h0000;
      reg_ack_out <= reg_req_in.rd || wr;
      reg_err_out <= (reg_req_in.rd || wr) && !hit;
    end
  end

  // checks
  a_period_clamp: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    half_ev && out_of_range |=> period_q == $past(max_ticks))
    else $error("out of range period not replaced by longest limit");
  a_period_update: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    half_ev && !out_of_range |=> period_q == $past(raw_period[15:0]))
    else $error("period reading not updated from measurement");
  a_wait_source: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    state_q == ST_WAIT_ON && !on_req |=> state_q == ST_WAIT_ON)
    else $error("measuring began without on request");
  a_start_gate: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    go_q |-> $past(state_q) == ST_DETECT && $past(rms_line_in > start_thr_q)
      && !status_q[STAT_BROWNOUT_BIT])
    else $error("soft start without rms over start threshold");
  a_sag_flag: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    sag_trip |=> status_q[STAT_SAG_BIT] && sag_live_q)
    else $error("sag flag or live sag wrong");
  a_sag_release: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    sag_live_q && !below |=> !sag_live_q)
    else $error("live sag kept after line recovered");
  a_line_good: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    $rose(sag_live_q) |-> line_good_n_out ##0 $past(state_q) == ST_RUN)
    else $error("line good not low-active on sag");
  a_uv_only: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    uv_shutdown_out |-> $past(rms_line_in) < $past(uv_limit_q))
    else $error("shutdown without uv limit crossing");
  a_zero_mid: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    fall_raw |=> info_q.zero_cross_valid && info_q.zero_cross_stamp == $past(mid_stamp))
    else $error("zero crossing not at midpoint");
  a_both_sinks: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ctrl_line_info_out.period_valid |-> meter_line_info_out.period == ctrl_line_info_out.period)
    else $error("control and metering disagree");
endmodule : line_monitor

//--- verif/line_sense_model.sv
// Purpose: rectified line sense source for the line monitor bench
// Assumes: one sample every cycle, triangle shaped half cycles
// Notes: a dropped line reads zero, as a missing line cycle does
`timescale 1ns/1ns
module line_sense_model #(
  parameter int HALF_CYC = 5000
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic drop_in,
  output logic sense_valid_out,
  output logic [15:0] sense_out,
  output logic [15:0] rms_out
);
  int phase_q;
  int tri_v;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || phase_q == HALF_CYC - 1) begin
      phase_q <= 0;
    end else begin
      phase_q <= phase_q + 1;
    end
  end
  // top 7 bits swing 0..127 so every half cycle gives exactly one falling crossing
  always_comb begin
    tri_v = (phase_q < HALF_CYC / 2) ? phase_q : HALF_CYC - phase_q;
    tri_v = tri_v * 254 / HALF_CYC;
    if (tri_v > 127) begin
      tri_v = 127;
    end
  end
  assign sense_valid_out = 1'b1;
  assign sense_out = drop_in ? 16'h0000 : {tri_v[6:0], 9'h000};
  assign rms_out = drop_in ? 16'h0000 : 16'h0200;
endmodule : line_sense_model

//--- verif/testbench.sv
// Purpose: self-checking bench for the line monitor and startup gate
// Assumes: 4 ns clock; line half period of 5000 cycles, 2 ticks
// Notes: period limits are set small so clamps and timeouts show in a short run
`timescale 1ns/1ns
module testbench;
  import line_mon_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic pin = 1'b0;
  logic drop = 1'b0;
  reg_req_t req = '0;
  logic sense_valid, ack, err, go, conv_on, line_good_n, uv_off;
  logic [15:0] sense, rms, rdata, rdv;
  logic errv;
  line_info_t ctrl_info, meter_info;
  int failures = 0;
  int num_checks = 0;
  int info_cnt = 0;

  always #2 clk_sys_in = ~clk_sys_in;
  // counted mid-cycle, away from the edge that launches the record
  always @(negedge clk_sys_in) if (ctrl_info.period_valid === 1'b1) info_cnt++;

  line_sense_model #(.HALF_CYC(5000)) i_line (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .drop_in(drop), .sense_valid_out(sense_valid), .sense_out(sense), .rms_out(rms));
  line_monitor i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .supply_on_request_in(pin), .sense_valid_in(sense_valid),
    .rectified_line_sense_in(sense), .rms_line_in(rms), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_ack_out(ack), .reg_err_out(err),
    .ctrl_line_info_out(ctrl_info), .meter_line_info_out(meter_info),
    .soft_start_go_out(go), .converter_on_out(conv_on), .line_good_n_out(line_good_n),
    .uv_shutdown_out(uv_off));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // request held over one edge, answer taken one cycle later
  task automatic reg_op(input logic w, input logic [15:0] a, input logic [15:0] d);
    req = '{w, ~w, a, d};
    @(posedge clk_sys_in);
    #1;
    req = '0;
    check(16'(ack), 16'h0001, "register answer missing");
    rdv = rdata;
    errv = err;
    @(posedge clk_sys_in);
    #1;
  endtask : reg_op

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_op(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    reg_op(1'b0, a, 16'h0000);
    check(rdv, e, "read data");
    check(16'(errv), 16'h0000, "error flag");
  endtask : rd_chk

  function automatic logic cond(input int w);
    case (w)
      0: return ctrl_info.period_valid;
      1: return go;
      2: return line_good_n;
      default: return ~line_good_n;
    endcase
  endfunction : cond

  // bounded wait; a missing event counts as a mismatch
  task automatic wait_for(input int w, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end while (cond(w) !== 1'b1 && n < lim);
    check(16'(cond(w)), 16'h0001, "awaited event missing");
  endtask : wait_for

  initial begin
    repeat (8) @(posedge clk_sys_in);
    #1;
    srst_in = 1'b0;
    rd_chk(ADDR_ON_OFF_SOURCE, {8'h00, SOURCE_RST});
    rd_chk(ADDR_CROSS_LEVEL, {8'h00, CROSS_LEVEL_RST});
    rd_chk(ADDR_MIN_PERIOD, {8'h00, MIN_PERIOD_RST});
    rd_chk(ADDR_MAX_PERIOD, {8'h00, MAX_PERIOD_RST});
    rd_chk(ADDR_INPUT_STATUS, {8'h00, STATUS_RST});
    rd_chk(ADDR_START_THR, 16'h0000);
    rd_chk(ADDR_WARN_THR, 16'h0000);
    rd_chk(ADDR_UV_LIMIT, 16'h0000);
    reg_op(1'b0, 16'h1234, 16'h0000);
    check(16'(errv), 16'h0001, "unmapped error");
    check(rdv, 16'h0000, "unmapped data");
    for (int m = 3; m >= 0; m--) begin
      wr(ADDR_SAG_CFG, 16'(m << SAG_MODE_LSB));
      rd_chk(ADDR_SAG_CFG, 16'(m << SAG_MODE_LSB));
    end
    $display("test registers done");
    wr(ADDR_START_THR, 16'h0100);
    wr(ADDR_WARN_THR, 16'h1000);
    wr(ADDR_MIN_PERIOD, 16'h0000);
    wr(ADDR_MAX_PERIOD, 16'h0002);
    // both sources, pin active low: pin alone must not start
    wr(ADDR_ON_OFF_SOURCE, 16'h000C);
    repeat (11000) @(posedge clk_sys_in);
    #1;
    check(16'(info_cnt), 16'h0000, "measured while off");
    check(16'(conv_on), 16'h0000, "on without command");
    wr(ADDR_ON_OFF_CMD, 16'h0080);
    wait_for(1, 40000);
    check(16'(conv_on), 16'h0001, "converter on");
    rd_chk(ADDR_INPUT_STATUS, 16'h0000);
    $display("test startup done");
    wait_for(0, 20000);
    wait_for(0, 20000);
    check(16'(ctrl_info.zero_cross_valid), 16'h0001, "zero cross with period");
    check(16'(meter_info === ctrl_info), 16'h0001, "metering copy");
    reg_op(1'b0, ADDR_LINE_PERIOD, 16'h0000);
    check(16'(rdv >= 16'h0003 && rdv <= 16'h0005), 16'h0001, "period in range");
    reg_op(1'b0, ADDR_LINE_AVG, 16'h0000);
    check(16'(rdv[15:7]), 16'h0000, "average width");
    $display("test period done");
    wr(ADDR_MIN_PERIOD, 16'h0001);
    wr(ADDR_MAX_PERIOD, 16'h0001);
    wait_for(0, 20000);
    wait_for(0, 20000);
    check(ctrl_info.period, 16'h000A, "below shortest");
    check(meter_info.period, 16'h000A, "metering period");
    wr(ADDR_LINE_PERIOD, 16'hFFFF);
    rd_chk(ADDR_LINE_PERIOD, 16'h000A);
    $display("test clamp done");
    // half of the clamped 10-tick period: 5 ticks, a quarter would have tripped by now
    wr(ADDR_SAG_CFG, 16'h0008);
    drop = 1'b1;
    repeat (10000) @(posedge clk_sys_in);
    #1;
    check(16'(line_good_n), 16'h0000, "sag before half period");
    wait_for(2, 20000);
    check(16'(conv_on), 16'h0001, "no action on sag");
    check(16'(uv_off), 16'h0000, "no shutdown on sag");
    rd_chk(ADDR_INPUT_STATUS, 16'h0028);
    wait_for(0, 40000);
    check(ctrl_info.period, 16'h000A, "no crossing period");
    check(16'(ctrl_info.zero_cross_valid), 16'h0000, "no crossing record");
    drop = 1'b0;
    wait_for(3, 20000);
    reg_op(1'b0, ADDR_INPUT_STATUS, 16'h0000);
    check(16'(rdv[STAT_SAG_BIT]), 16'h0001, "sag flag kept");
    wr(ADDR_INPUT_STATUS, 16'h0020);
    reg_op(1'b0, ADDR_INPUT_STATUS, 16'h0000);
    check(16'(rdv[STAT_SAG_BIT]), 16'h0000, "sag flag cleared");
    $display("test sag done");
    complete_run();
  end

  // full sequence needs about 67k cycles; the watchdog allows 90k
  initial begin
    #360000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : testbench
